// [hdl/ptd_decoder.sv]
// Purpose: decode transfer field of a parallel instruction word
// Assumes: issue logic presents one opcode per op_valid cycle
// Notes: results are registered one cycle after op_valid

// What this block does
// - move source = source bank joined with low bits
// - move destination low bits from opcode 5..3
// - field move: d source, any dest, absolute
// - item select picks byte or halfword
// - field destination upper bits from 21..18
// - field source low bits from 12..10
// - extract extends by sign select, replicate ignores
// - field size byte/halfword, 1x reserved
// - replicate lowest item across 32 bits
// - extract chosen item then extend
// - field destination low bits from 5..3
// - local long offset uses global port
// - local long register = bank plus d field
// - local long offset or index code
// - global long offset or index code
// - global register = bank plus reg field
// - relative mode: absolute, lram0, param, reserved
// - non-d format: banks, global port, short index
// - alu destination bank joins destination field
// - alu source one bank joins source field
// - load and extend bits pick transfer type
// - scale index by one or two bits
// - zero register move destination sends interprocessor command
module ptd_decoder (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // issue side
  input wire logic op_valid,
  input wire ptd_pkg::ptd_fmt_t op_format,
  input wire logic [ptd_pkg::OP_W-1:0] opcode,
  input wire logic [2:0] du_dst_low,
  input wire logic [2:0] du_src1_low,
  input wire logic [31:0] move_src_data,
  // decoded outputs
  output ptd_pkg::ptd_xfer_dec_t local_dec,
  output ptd_pkg::ptd_xfer_dec_t global_dec,
  output ptd_pkg::ptd_move_dec_t move_dec,
  output ptd_pkg::ptd_field_dec_t field_dec,
  output ptd_pkg::ptd_alu_dec_t alu_dec,
  output logic [31:0] ipc_data,
  output logic ipc_valid,
  output logic illegal
);
  import ptd_pkg::*;

  function automatic logic [1:0] scale_of(input logic [1:0] sz,
                                           input logic s);
    if (!s) scale_of = 2'h0;
    else if (sz == SZ_HALF) scale_of = 2'h1;
    else if (sz == SZ_WORD) scale_of = 2'h2;
    else scale_of = 2'h0;
  endfunction

  // byte accesses gain the s bit as offset msb
  function automatic logic [15:0] long_off(input logic [14:0] off,
                                           input logic [1:0] sz,
                                           input logic s);
    long_off = (sz == SZ_BYTE) ? {s, off} : {1'b0, off};
  endfunction

  function automatic logic [31:0] field_op(input logic [31:0] d,
                                           input logic [1:0] sz,
                                           input logic [1:0] itm,
                                           input logic sgn,
                                           input logic rep);
    logic [7:0] b;
    logic [15:0] h;
    b = d[8*itm +: 8];
    h = itm[0] ? d[31:16] : d[15:0];
    if (rep && sz == SZ_BYTE) field_op = {4{d[7:0]}};
    else if (rep) field_op = {2{d[15:0]}};
    else if (sz == SZ_BYTE)
      field_op = {{24{sgn & b[7]}}, b};
    else field_op = {{16{sgn & h[15]}}, h};
  endfunction

  function automatic logic rsvd_size(input logic [1:0] sz);
    rsvd_size = (sz == 2'h3);
  endfunction

  // registers
  logic [1:0] ctrl;
  logic [1:0] status;
  logic [31:0] dec_cnt;
  logic [31:0] ill_cnt;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic ill_clr;

  // combinational decode
  ptd_xfer_dec_t next_local;
  ptd_xfer_dec_t next_global;
  ptd_move_dec_t next_move;
  ptd_field_dec_t next_field;
  ptd_alu_dec_t next_alu;
  logic next_illegal;
  logic fire;

  logic [1:0] lsz;
  logic [1:0] lrm;
  ptd_xfer_t lxf;

  assign lsz = opcode[30:29];
  assign lrm = opcode[23:22];
  assign lxf = ptd_xfer_t'({opcode[17], opcode[31]});
  assign fire = ce & op_valid & ctrl[CTRL_EN_BIT];

  always_comb begin
    next_local = '0;
    next_global = '0;
    next_move = '0;
    next_field = '0;
    next_alu = '0;
    next_illegal = 1'b0;
    // shared short-offset local transfer fields
    next_local.mode = opcode[38:35];
    next_local.xfer = lxf;
    next_local.size = lsz;
    next_local.scale_shift = scale_of(lsz, opcode[28]);
    next_local.data_reg = {DREG_BANK, opcode[34:32]};
    next_local.base_reg = opcode[27:25];
    next_local.index_reg = opcode[2:0];
    next_local.offset = {12'h000, opcode[28] & (lsz == SZ_BYTE),
                         opcode[2:0]};
    next_local.rel_mode = lrm;
    case (op_format)
      FMT_MOVE_LOCAL: begin
        next_local.valid = 1'b1;
        next_move.valid = 1'b1;
        next_move.src = {opcode[9:6], opcode[12:10]};
        next_move.dst = {opcode[21:18], opcode[5:3]};
        next_move.ipc_cmd = ({opcode[21:18], opcode[5:3]} ==
                             ZERO_REG_CODE);
        next_illegal = rsvd_size(lsz) | (lrm == RM_RSVD);
      end
      FMT_FIELD_LOCAL: begin
        next_local.valid = 1'b1;
        next_local.rel_mode = RM_ABS;
        next_field.valid = 1'b1;
        next_field.src = {DREG_BANK, opcode[12:10]};
        next_field.dst = {opcode[21:18], opcode[5:3]};
        next_field.result = field_op(move_src_data, opcode[8:7],
                                     opcode[23:22], opcode[9],
                                     opcode[6]);
        next_illegal = opcode[8] | rsvd_size(lsz);
      end
      FMT_LOCAL_LONG: begin
        next_local.valid = 1'b1;
        next_local.via_global_port = 1'b1;
        next_local.data_reg = {opcode[21:18], opcode[34:32]};
        next_local.offset = long_off(opcode[14:0], lsz, opcode[28]);
        next_illegal = rsvd_size(lsz) | (lrm == RM_RSVD);
      end
      FMT_GLOBAL_LONG: begin
        next_local.valid = 1'b0;
        next_global.valid = 1'b1;
        next_global.via_global_port = 1'b1;
        next_global.mode = opcode[16:13];
        next_global.xfer = ptd_xfer_t'({opcode[17], opcode[9]});
        next_global.size = opcode[8:7];
        next_global.scale_shift = scale_of(opcode[8:7], opcode[6]);
        next_global.data_reg = {opcode[21:18], opcode[12:10]};
        next_global.base_reg = opcode[5:3];
        next_global.index_reg = opcode[24:22];
        next_global.offset = long_off(opcode[36:22], opcode[8:7],
                                      opcode[6]);
        next_global.rel_mode = opcode[1:0];
        next_illegal = rsvd_size(opcode[8:7]) |
                       (opcode[1:0] == RM_RSVD);
      end
      FMT_NOND_LOCAL: begin
        next_local.valid = 1'b1;
        next_local.via_global_port = 1'b1;
        next_alu.valid = 1'b1;
        next_alu.dst = {opcode[21:18], du_dst_low};
        next_alu.src1 = {opcode[9:6], du_src1_low};
        next_illegal = rsvd_size(lsz) | (lrm == RM_RSVD);
      end
      default: begin
        next_local.valid = 1'b0;
      end
    endcase
    // illegal opcodes perform nothing
    if (next_illegal) begin
      next_local.valid = 1'b0;
      next_global.valid = 1'b0;
      next_move.valid = 1'b0;
      next_field.valid = 1'b0;
      next_alu.valid = 1'b0;
    end
  end

  // decoded output registers: valid pulses, fields hold for late readers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_dec <= '0;
    end else if (ce) begin
      if (fire) begin
        local_dec <= next_local;
      end else begin
        local_dec.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_dec <= '0;
    end else if (ce) begin
      if (fire) begin
        global_dec <= next_global;
      end else begin
        global_dec.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      move_dec <= '0;
    end else if (ce) begin
      if (fire) begin
        move_dec <= next_move;
      end else begin
        move_dec.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_dec <= '0;
    end else if (ce) begin
      if (fire) begin
        field_dec <= next_field;
      end else begin
        field_dec.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alu_dec <= '0;
    end else if (ce) begin
      if (fire) begin
        alu_dec <= next_alu;
      end else begin
        alu_dec.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      illegal <= 1'b0;
    end else if (ce) begin
      illegal <= fire & next_illegal;
    end
  end

  // zero register move destination becomes a command, not a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ipc_valid <= 1'b0;
      ipc_data <= '0;
    end else if (ce) begin
      ipc_valid <= fire & next_move.valid & next_move.ipc_cmd &
                   ctrl[CTRL_IPC_BIT];
      if (fire & next_move.ipc_cmd)
        ipc_data <= move_src_data;
    end
  end

  // ahb-lite: zero wait states, always okay
  logic addr_ok;
  assign addr_ok = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ill_clr = wr_pend & (wr_addr == REG_ILL_CNT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (ce) begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
    end else if (ce && wr_pend && wr_addr == REG_CTRL) begin
      ctrl <= hwdata[1:0];
    end
  end

  // counters: a software clear in the same cycle as a fresh event leaves a count of one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_cnt <= '0;
    end else if (ce) begin
      if (wr_pend && wr_addr == REG_DEC_CNT)
        dec_cnt <= {31'h0, fire};
      else if (fire)
        dec_cnt <= dec_cnt + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ill_cnt <= '0;
    end else if (ce) begin
      if (ill_clr)
        ill_cnt <= {31'h0, fire & next_illegal};
      else if (fire & next_illegal)
        ill_cnt <= ill_cnt + 32'h1;
    end
  end

  // status only follows decoded opcodes, bus traffic leaves it alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else if (ce && fire) begin
      status[ST_ILL_BIT] <= next_illegal;
      status[ST_IPC_BIT] <= next_move.valid & next_move.ipc_cmd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (ce && addr_ok && !hwrite) begin
      case (haddr)
        REG_CTRL: hrdata <= {30'h0, ctrl};
        REG_STATUS: hrdata <= {30'h0, status};
        REG_DEC_CNT: hrdata <= dec_cnt;
        REG_ILL_CNT: hrdata <= ill_cnt;
        REG_FIELD_RES: hrdata <= field_dec.result;
        REG_MOVE_CODES: hrdata <= {17'h0, move_dec.src, 1'b0,
                                   move_dec.dst};
        default: hrdata <= '0;
      endcase
    end
  end
endmodule

// [hdl/ptd_pkg.sv]
// Purpose: shared constants and types for the transfer field decoder
// Assumes: opcode transfer part is bits 38..0 of the issued word
// Notes: register offsets are byte addresses on the ahb-lite slave
package ptd_pkg;
  localparam int OP_W = 39;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DEC_CNT = 8'h08;
  localparam logic [7:0] REG_ILL_CNT = 8'h0c;
  localparam logic [7:0] REG_FIELD_RES = 8'h10;
  localparam logic [7:0] REG_MOVE_CODES = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_IPC_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int ST_ILL_BIT = 0;
  localparam int ST_IPC_BIT = 1;
  // code of the read-only zero register, arbitrary placement
  localparam logic [6:0] ZERO_REG_CODE = 7'h0f;
  // upper bits of a d register code
  localparam logic [3:0] DREG_BANK = 4'h0;
  // size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // relative addressing codes
  localparam logic [1:0] RM_ABS = 2'h0;
  localparam logic [1:0] RM_RSVD = 2'h1;
  localparam logic [1:0] RM_LRAM0 = 2'h2;
  localparam logic [1:0] RM_PRAM = 2'h3;
  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic [2:0] {
    FMT_MOVE_LOCAL = 3'b010,
    FMT_FIELD_LOCAL = 3'b011,
    FMT_LOCAL_LONG = 3'b100,
    FMT_GLOBAL_LONG = 3'b101,
    FMT_NOND_LOCAL = 3'b110
  } ptd_fmt_t;

  // {load, extend} pairs
  typedef enum logic [1:0] {
    XF_STORE = 2'b00,
    XF_ADDR_ARITH = 2'b01,
    XF_LOAD_ZERO = 2'b10,
    XF_LOAD_SIGN = 2'b11
  } ptd_xfer_t;

  typedef struct packed {
    logic valid;
    logic via_global_port;
    logic [3:0] mode;
    ptd_xfer_t xfer;
    logic [1:0] size;
    logic [1:0] scale_shift;
    logic [6:0] data_reg;
    logic [2:0] base_reg;
    logic [2:0] index_reg;
    logic [15:0] offset;
    logic [1:0] rel_mode;
  } ptd_xfer_dec_t;

  typedef struct packed {
    logic valid;
    logic ipc_cmd;
    logic [6:0] src;
    logic [6:0] dst;
  } ptd_move_dec_t;

  typedef struct packed {
    logic valid;
    logic [6:0] src;
    logic [6:0] dst;
    logic [31:0] result;
  } ptd_field_dec_t;

  typedef struct packed {
    logic valid;
    logic [6:0] dst;
    logic [6:0] src1;
  } ptd_alu_dec_t;
endpackage

// [test/ptd_issue_model.sv]
// Purpose: issue-side stand-in feeding opcodes to the decoder
// Assumes: one opcode per call, valid for one cycle
// Notes: idle data lines show inverted values, op_format keeps its last value
module ptd_issue_model (
  // clock
  input wire logic hclk,
  // issue side
  output logic op_valid,
  output ptd_pkg::ptd_fmt_t op_format,
  output logic [ptd_pkg::OP_W-1:0] opcode,
  output logic [2:0] du_dst_low,
  output logic [2:0] du_src1_low,
  output logic [31:0] move_src_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import ptd_pkg::*;
  initial begin
    op_valid = 1'b0;
    op_format = FMT_MOVE_LOCAL;
    {opcode, du_dst_low, du_src1_low, move_src_data} = '0;
  end
  task go(input ptd_fmt_t f, input logic [OP_W-1:0] o,
          input logic [31:0] v, input logic [2:0] a, input logic [2:0] b);
    @(posedge hclk);
    op_valid <= 1'b1;
    op_format <= f;
    {opcode, du_dst_low, du_src1_low, move_src_data} <= {o, a, b, v};
    @(posedge hclk);
    op_valid <= 1'b0;
    // inverted so a decoder reading late sees garbage
    {opcode, du_dst_low, du_src1_low, move_src_data} <= ~{o, a, b, v};
  endtask
endmodule

// [test/ptd_decoder_chk.sv]
// Purpose: port-level checks on the decoder
// Assumes: ce held high, results one cycle after op_valid
// Notes: bound from the bench top
module ptd_decoder_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // issue side
  input wire logic op_valid,
  input wire ptd_pkg::ptd_fmt_t op_format,
  input wire logic [ptd_pkg::OP_W-1:0] opcode,
  input wire logic [2:0] du_dst_low,
  input wire logic [2:0] du_src1_low,
  input wire logic [31:0] move_src_data,
  // decoded
  input wire ptd_pkg::ptd_xfer_dec_t local_dec,
  input wire ptd_pkg::ptd_xfer_dec_t global_dec,
  input wire ptd_pkg::ptd_move_dec_t move_dec,
  input wire ptd_pkg::ptd_field_dec_t field_dec,
  input wire ptd_pkg::ptd_alu_dec_t alu_dec,
  input wire logic [31:0] ipc_data,
  input wire logic ipc_valid,
  input wire logic illegal
);
  timeunit 1ns;
  timeprecision 1ns;
  import ptd_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  move_codes_a: assert property (
    move_dec.valid |-> {move_dec.src, move_dec.dst} == $past({opcode[9:6],
    opcode[12:10], opcode[21:18], opcode[5:3]})) else $error("move codes");
  field_codes_a: assert property (
    field_dec.valid |-> {field_dec.src, field_dec.dst} == {DREG_BANK,
    $past({opcode[12:10], opcode[21:18], opcode[5:3]})}) else $error("fld");
  global_reg_a: assert property (
    global_dec.valid |-> {global_dec.data_reg, global_dec.rel_mode} ==
    $past({opcode[21:18], opcode[12:10], opcode[1:0]})) else $error("glob");
  alu_codes_a: assert property (
    alu_dec.valid |-> {alu_dec.dst, alu_dec.src1} == $past({opcode[21:18],
    du_dst_low, opcode[9:6], du_src1_low})) else $error("alu codes");
  long_port_a: assert property (
    local_dec.valid && $past(op_format) == FMT_LOCAL_LONG |->
    local_dec.via_global_port && !global_dec.valid) else $error("port");
  ipc_data_a: assert property (
    ipc_valid |-> ipc_data == $past(move_src_data) && move_dec.valid &&
    move_dec.dst == ZERO_REG_CODE) else $error("ipc data");
  illegal_quiet_a: assert property (
    illegal |-> !(local_dec.valid || global_dec.valid || move_dec.valid ||
    field_dec.valid || alu_dec.valid)) else $error("illegal with valid");
  rsvd_rel_a: assert property (
    op_valid && op_format == FMT_GLOBAL_LONG && opcode[1:0] == RM_RSVD
    |=> !global_dec.valid) else $error("reserved mode decoded");
  cover property (ipc_valid);
  cover property (illegal);
  cover property (field_dec.valid && $past(opcode[6]));
endmodule

// [test/tb.sv]
// Purpose: self-checking bench for the transfer field decoder
// Assumes: single ahb-lite slave, ce low only in its own scenario
// Notes: expectations come from bench functions only
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ptd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, op_valid, ipc_valid, illegal;
  logic [31:0] hrdata, ipc_data, rd, d;
  ptd_fmt_t op_format, f;
  logic [OP_W-1:0] opcode, op;
  logic [2:0] du_dst_low, du_src1_low, dl, sl;
  logic [31:0] move_src_data;
  ptd_xfer_dec_t local_dec, global_dec;
  ptd_move_dec_t move_dec;
  ptd_field_dec_t field_dec;
  ptd_alu_dec_t alu_dec;
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 32'hf8c1;
  ptd_fmt_t fmts [5] = '{FMT_MOVE_LOCAL, FMT_FIELD_LOCAL, FMT_LOCAL_LONG,
                         FMT_GLOBAL_LONG, FMT_NOND_LOCAL};
  initial forever #25 hclk = ~hclk;
  ptd_decoder u_dut (.hready(hreadyout), .*);
  ptd_issue_model u_iss (.*);
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > 40) begin
        err_count++;
        conclude();
      end
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, HTRANS_NONSEQ, a, w, 3'h2};
    @(posedge hclk);
    wait_rdy();
    {hsel, htrans} <= 3'h0;
    hwdata <= wd;
    @(posedge hclk);
    wait_rdy();
    rd = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(hresp, 1'b0);
  endtask
  task issue(input ptd_fmt_t g, input logic [OP_W-1:0] o);
    u_iss.go(g, o, d, dl, sl);
    #1;
  endtask
  function logic [31:0] fexp(input logic [OP_W-1:0] o, input logic [31:0] s);
    logic [7:0] b;
    logic [15:0] h;
    b = s[o[23:22]*8 +: 8];
    h = o[22] ? s[31:16] : s[15:0];
    if (o[6]) return o[7] ? {2{s[15:0]}} : {4{s[7:0]}};
    if (o[7]) return o[9] ? {{16{h[15]}}, h} : {16'h0, h};
    return o[9] ? {{24{b[7]}}, b} : {24'h0, b};
  endfunction
  function logic bad(input ptd_fmt_t g, input logic [OP_W-1:0] o);
    if (g == FMT_GLOBAL_LONG) return o[8:7] == 2'h3 || o[1:0] == RM_RSVD;
    if (g == FMT_FIELD_LOCAL) return o[30:29] == 2'h3 || o[8];
    return o[30:29] == 2'h3 || o[23:22] == RM_RSVD;
  endfunction
  task check_op(input ptd_fmt_t g, input logic [OP_W-1:0] o);
    chk(illegal, bad(g, o));
    if (bad(g, o)) return;
    case (g)
      FMT_MOVE_LOCAL: begin
        chk(move_dec.valid, 1'b1);
        chk(move_dec.src, {o[9:6], o[12:10]});
        chk(move_dec.dst, {o[21:18], o[5:3]});
        chk(local_dec.xfer, {o[17], o[31]});
      end
      FMT_FIELD_LOCAL: begin
        chk(field_dec.valid, 1'b1);
        chk(field_dec.src, {DREG_BANK, o[12:10]});
        chk(field_dec.dst, {o[21:18], o[5:3]});
        chk(field_dec.result, fexp(o, d));
        chk(local_dec.rel_mode, RM_ABS);
      end
      FMT_LOCAL_LONG: begin
        chk(local_dec.via_global_port, 1'b1);
        chk(global_dec.valid, 1'b0);
        chk(local_dec.data_reg, {o[21:18], o[34:32]});
        chk(local_dec.offset[14:0], o[14:0]);
        chk(local_dec.scale_shift, o[28] ? o[30:29] : 2'h0);
      end
      FMT_GLOBAL_LONG: begin
        chk(global_dec.valid, 1'b1);
        chk(global_dec.data_reg, {o[21:18], o[12:10]});
        chk(global_dec.offset[14:0], o[36:22]);
        chk(global_dec.rel_mode, o[1:0]);
        chk(global_dec.xfer, {o[17], o[9]});
      end
      default: begin
        chk({alu_dec.valid, alu_dec.dst}, {1'b1, o[21:18], dl});
        chk(alu_dec.src1, {o[9:6], sl});
        chk(local_dec.via_global_port, 1'b1);
      end
    endcase
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(REG_CTRL, {30'h0, CTRL_RESET});
    rchk(8'h20, 32'h0);
    for (int i = 0; i < 300; i++) begin
      f = fmts[$unsigned($random(seed)) % 5];
      op = {$random(seed), $random(seed)};
      {d, dl, sl} = {$random(seed), $random(seed)};
      issue(f, op);
      check_op(f, op);
    end
    $display("random decode done");
    // field corners: every item, size, sign and replicate choice
    d = 32'hf07f8001;
    for (int i = 0; i < 32; i++) begin
      op = '0;
      {op[6], op[7], op[9], op[23:22]} = i[4:0];
      issue(FMT_FIELD_LOCAL, op);
      check_op(FMT_FIELD_LOCAL, op);
    end
    rchk(REG_FIELD_RES, fexp(op, d));
    $display("field corners done");
    op = '0;
    {op[21:18], op[5:3]} = ZERO_REG_CODE;
    ahb(1'b1, REG_CTRL, 32'h1);
    issue(FMT_MOVE_LOCAL, op);
    chk({move_dec.valid, ipc_valid}, 2'b10);
    ahb(1'b1, REG_CTRL, 32'h0);
    issue(FMT_MOVE_LOCAL, op);
    chk(move_dec.valid, 1'b0);
    ahb(1'b1, REG_CTRL, 32'h3);
    ahb(1'b1, REG_DEC_CNT, 32'h0);
    d = 32'h8765fedc;
    issue(FMT_MOVE_LOCAL, op);
    chk(ipc_valid, 1'b1);
    chk(ipc_data, d);
    rchk(REG_STATUS, 32'h2);
    rchk(REG_DEC_CNT, 32'h1);
    op[1:0] = RM_RSVD;
    issue(FMT_GLOBAL_LONG, op);
    check_op(FMT_GLOBAL_LONG, op);
    rchk(REG_STATUS, 32'h1);
    // a low enable must freeze decode and the counters
    @(posedge hclk);
    ce <= 1'b0;
    issue(FMT_MOVE_LOCAL, op);
    chk({move_dec.valid, ipc_valid}, 2'b00);
    @(posedge hclk);
    ce <= 1'b1;
    rchk(REG_DEC_CNT, 32'h2);
    $display("control and status done");
    conclude();
  end
endmodule
bind ptd_decoder ptd_decoder_chk u_chk (.*);
